// ===== hdl/bsc_chain.sv
// Boundary-scan cell chain with instruction register, bypass and identification paths.
//
// Contract
// R1: Serial output enabled on entering shift states.
// R2: Serial output floats on leaving shift states.
// R3: Capture cells on rising clock in Capture-DR.
// R4: Controller holds mode-select high releasing test reset.
// R5: Logic state held while test clock stopped.
// R6: Scan-driven pin values change after falling edge.
// R7: Enable cells switch pin drivers during test.
// R8: Cells chained in order, cell one nearest input.
// R9: Extra cell controls whole data bus enable.
// R10: Controller preloads guard values before external test.
// R11: Boundary contents undefined after reset or power-up.
// R12: Serial output changes on falling test clock.
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_chain #(
    parameter int CELLS = `BSC_CELLS,
    parameter int DBE_CELL = `BSC_DBE_CELL,
    // Arbitrary identification value; bit 0 stays one as the scan standard asks.
    parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic [CELLS-1:0] cell_capture,
    output logic tdo,
    output logic tdo_oe,
    output logic [CELLS-1:0] cell_update,
    output logic scan_drive,
    output logic scan_highz,
    output logic data_bus_oe
);
    logic [`BSC_PIN_SYNCS-1:0] pin_meta;
    logic [`BSC_PIN_SYNCS-1:0] pin_sync;
    logic tck_prev;
    logic [`BSC_IR_WIDTH-1:0] ir_shift;
    logic [`BSC_IR_WIDTH-1:0] ir;
    logic bypass_bit;
    logic [`BSC_ID_WIDTH-1:0] id_shift;
    logic [CELLS-1:0] bsr_shift;
    bsc_pkg::bsc_tap_t state;

    wire tck_s = pin_sync[0];
    wire tms_s = pin_sync[1];
    wire tdi_s = pin_sync[2];
    wire trst_s = pin_sync[3];
    wire tck_rise = tck_s & ~tck_prev;
    wire tck_fall = ~tck_s & tck_prev;

    wire sel_bsr = (ir == `BSC_IR_SAMPLE) || (ir == `BSC_IR_EXTEST);
    wire sel_id = (ir == `BSC_IR_IDCODE);
    wire in_sh_dr = (state == bsc_pkg::BSC_SH_DR);
    wire in_sh_ir = (state == bsc_pkg::BSC_SH_IR);
    wire in_cap_dr = (state == bsc_pkg::BSC_CAP_DR);
    wire dr_out = sel_bsr ? bsr_shift[CELLS-1] : (sel_id ? id_shift[0] : bypass_bit);
    wire next_tdo = in_sh_ir ? ir_shift[0] : dr_out;
    wire next_drive = (ir == `BSC_IR_EXTEST) || (ir == `BSC_IR_CLAMP);
    wire next_highz = (ir == `BSC_IR_HIGHZ);

    // Pins come from the controller's domain; only the second stage is read.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            tck_prev <= 1'b0;
        end else begin
            pin_meta <= {trst_n, tdi, tms, tck};
            pin_sync <= pin_meta;
            tck_prev <= pin_sync[0];
        end
    end

    bsc_tap u_tap (
        .clk(clk),
        .resetn(resetn),
        .tck_rise(tck_rise),
        .tms(tms_s),
        .trst_n(trst_s),
        .state(state)
    );

    // Instruction path: shifts on rise, takes effect on the fall in Update-IR.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ir_shift <= 5'h00;
            ir <= `BSC_IR_IDCODE;
        end else if (!trst_s || state == bsc_pkg::BSC_TLR) begin
            ir <= `BSC_IR_IDCODE;
        end else if (tck_rise && state == bsc_pkg::BSC_CAP_IR) begin
            ir_shift <= `BSC_IR_CAPTURE;
        end else if (tck_rise && in_sh_ir) begin
            ir_shift <= {tdi_s, ir_shift[`BSC_IR_WIDTH-1:1]};
        end else if (tck_fall && state == bsc_pkg::BSC_UPD_IR) begin
            ir <= ir_shift;
        end
    end

    // Bypass and identification paths.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bypass_bit <= 1'b0;
            id_shift <= 32'h0000_0000;
        end else if (tck_rise && in_cap_dr) begin
            bypass_bit <= 1'b0;
            id_shift <= ID_CODE;
        end else if (tck_rise && in_sh_dr) begin
            bypass_bit <= tdi_s;
            id_shift <= {tdi_s, id_shift[`BSC_ID_WIDTH-1:1]};
        end
    end

    // Boundary shift stage. Its contents carry no guarantee across a test reset, so nothing clears it
    // there; the controller must preload guard values before driving pins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bsr_shift <= '0; // R11
        end else if (tck_rise && in_cap_dr && sel_bsr) begin
            bsr_shift <= cell_capture; // R3
        end else if (tck_rise && in_sh_dr && sel_bsr) begin
            bsr_shift <= {bsr_shift[CELLS-2:0], tdi_s}; // R8
        end
    end

    // Update latch loads on the falling edge, so pin values never move on a rising edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cell_update <= '0; // R11
        end else if (tck_fall && state == bsc_pkg::BSC_UPD_DR && sel_bsr) begin
            cell_update <= bsr_shift; // R6
        end
    end

    // Serial output and its enable both move only on the falling edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= next_tdo; // R12
            tdo_oe <= in_sh_dr || in_sh_ir; // R1 R2
        end
    end

    // Pin mode follows the held instruction; the data bus enable comes from its own cell.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scan_drive <= 1'b0;
            scan_highz <= 1'b0;
            data_bus_oe <= 1'b0;
        end else begin
            scan_drive <= next_drive; // R7
            scan_highz <= next_highz;
            data_bus_oe <= next_drive && cell_update[DBE_CELL-1]; // R9
        end
    end
endmodule

// ===== hdl/bsc_defs.svh
// Constants for the boundary-scan cell chain: instruction codes, cell positions and widths.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

`define BSC_IR_WIDTH 5
`define BSC_IR_EXTEST 5'h00
`define BSC_IR_SAMPLE 5'h01
`define BSC_IR_CLAMP 5'h04
`define BSC_IR_HIGHZ 5'h05
`define BSC_IR_IDCODE 5'h06
`define BSC_IR_BYPASS 5'h1F
`define BSC_IR_CAPTURE 5'h01
`define BSC_ID_WIDTH 32
`define BSC_CELLS 130
`define BSC_DBE_CELL 111
`define BSC_PIN_SYNCS 4

`endif

// ===== hdl/bsc_pkg.sv
// Types shared by the boundary-scan cell chain modules.
package bsc_pkg;

    typedef enum logic [3:0] {
        BSC_TLR, BSC_RTI, BSC_SEL_DR, BSC_CAP_DR, BSC_SH_DR, BSC_EX1_DR, BSC_PAU_DR, BSC_EX2_DR, BSC_UPD_DR,
        BSC_SEL_IR, BSC_CAP_IR, BSC_SH_IR, BSC_EX1_IR, BSC_PAU_IR, BSC_EX2_IR, BSC_UPD_IR
    } bsc_tap_t;

endpackage

// ===== hdl/bsc_tap.sv
// Test access port state machine, stepped on each sampled rising edge of the test clock.
`timescale 1ns/1ps
module bsc_tap (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck_rise,
    input wire logic tms,
    input wire logic trst_n,
    output bsc_pkg::bsc_tap_t state
);
    bsc_pkg::bsc_tap_t next_state;

    always_comb begin
        case (state)
            bsc_pkg::BSC_TLR: next_state = tms ? bsc_pkg::BSC_TLR : bsc_pkg::BSC_RTI;
            bsc_pkg::BSC_RTI: next_state = tms ? bsc_pkg::BSC_SEL_DR : bsc_pkg::BSC_RTI;
            bsc_pkg::BSC_SEL_DR: next_state = tms ? bsc_pkg::BSC_SEL_IR : bsc_pkg::BSC_CAP_DR;
            bsc_pkg::BSC_CAP_DR: next_state = tms ? bsc_pkg::BSC_EX1_DR : bsc_pkg::BSC_SH_DR;
            bsc_pkg::BSC_SH_DR: next_state = tms ? bsc_pkg::BSC_EX1_DR : bsc_pkg::BSC_SH_DR;
            bsc_pkg::BSC_EX1_DR: next_state = tms ? bsc_pkg::BSC_UPD_DR : bsc_pkg::BSC_PAU_DR;
            bsc_pkg::BSC_PAU_DR: next_state = tms ? bsc_pkg::BSC_EX2_DR : bsc_pkg::BSC_PAU_DR;
            bsc_pkg::BSC_EX2_DR: next_state = tms ? bsc_pkg::BSC_UPD_DR : bsc_pkg::BSC_SH_DR;
            bsc_pkg::BSC_UPD_DR: next_state = tms ? bsc_pkg::BSC_SEL_DR : bsc_pkg::BSC_RTI;
            bsc_pkg::BSC_SEL_IR: next_state = tms ? bsc_pkg::BSC_TLR : bsc_pkg::BSC_CAP_IR;
            bsc_pkg::BSC_CAP_IR: next_state = tms ? bsc_pkg::BSC_EX1_IR : bsc_pkg::BSC_SH_IR;
            bsc_pkg::BSC_SH_IR: next_state = tms ? bsc_pkg::BSC_EX1_IR : bsc_pkg::BSC_SH_IR;
            bsc_pkg::BSC_EX1_IR: next_state = tms ? bsc_pkg::BSC_UPD_IR : bsc_pkg::BSC_PAU_IR;
            bsc_pkg::BSC_PAU_IR: next_state = tms ? bsc_pkg::BSC_EX2_IR : bsc_pkg::BSC_PAU_IR;
            bsc_pkg::BSC_EX2_IR: next_state = tms ? bsc_pkg::BSC_UPD_IR : bsc_pkg::BSC_SH_IR;
            bsc_pkg::BSC_UPD_IR: next_state = tms ? bsc_pkg::BSC_SEL_DR : bsc_pkg::BSC_RTI;
            default: next_state = bsc_pkg::BSC_TLR;
        endcase
    end

    // The state only moves on a test clock edge or a test reset, so a parked clock holds it indefinitely.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= bsc_pkg::BSC_TLR;
        end else if (!trst_n) begin
            state <= bsc_pkg::BSC_TLR;
        end else if (tck_rise) begin
            state <= next_state; // R5
        end
    end
endmodule

// ===== verif/boundary_scan_cell_chain_tb.sv
// Self-checking bench for the boundary-scan cell chain.
`timescale 1ns/1ps
module boundary_scan_cell_chain_tb;
    logic clk, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe, scan_drive, scan_highz, data_bus_oe, o;
    logic [129:0] cell_capture, cell_update, got, v;
    int err_count = 0, checked = 0, cycles = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The identification value is arbitrary.
    bsc_chain #(.ID_CODE(32'h0000_00A7)) uut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .cell_capture(cell_capture), .tdo(tdo), .tdo_oe(tdo_oe), .cell_update(cell_update),
        .scan_drive(scan_drive), .scan_highz(scan_highz), .data_bus_oe(data_bus_oe));
    bsc_ctrl ctrl (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
    task automatic chk(input string what, input logic [129:0] seen, input logic [129:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic go(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) ctrl.step(seq[i], 1'b0, o);
    endtask
    task automatic ir_load(input logic [4:0] code);
        go(8'h03, 4);
        for (int i = 0; i < 5; i++) ctrl.step(i == 4, code[i], o);
        go(8'h01, 2);
    endtask
    // Shifts cell 130 out first; a long stop of the test clock sits in mid-shift.
    task automatic dr_scan(input logic [129:0] din, output logic [129:0] dout);
        go(8'h01, 3);
        for (int i = 0; i < 130; i++) begin
            if (i == 64) repeat (400) @(posedge clk);
            ctrl.step(i == 129, din[129-i], dout[129-i]);
            if (i == 1) chk("tdo_oe in shift", 130'(tdo_oe), 130'h1);
        end
        go(8'h01, 2);
    endtask
    task automatic t_sample();
        ir_load(5'h01);
        @(posedge clk) cell_capture <= {{4{32'hC3A5_0F96}}, 2'h2};
        v = {{4{32'h1234_5678}}, 2'h1};
        v[110] = 1'b1;
        dr_scan(v, got);
        chk("captured cells", got, {{4{32'hC3A5_0F96}}, 2'h2});
        chk("preloaded cells", cell_update, v);
        chk("tdo_oe after exit", 130'(tdo_oe), 130'h0);
        chk("drive in sample", 130'(scan_drive), 130'h0);
        $display("sample test done");
    endtask
    task automatic t_extest();
        ir_load(5'h00);
        chk("drive in extest", 130'(scan_drive), 130'h1);
        chk("bus enable on", 130'(data_bus_oe), 130'h1);
        v[110] = 1'b0;
        dr_scan(v, got);
        chk("bus enable off", 130'(data_bus_oe), 130'h0);
        chk("extest cells", cell_update, v);
        ctrl.tap_reset();
        go(8'h00, 1);
        chk("drive after test reset", 130'(scan_drive), 130'h0);
        // The identification path is selected after a test reset; its capture leaves lowest bit first.
        dr_scan(v, got);
        chk("id code out", 130'(got[129:98]), 130'(32'hE500_0000));
        chk("id tdi follows", 130'(got[97:0]), 130'(v[129:32]));
        ir_load(5'h05);
        chk("float in highz", 130'(scan_highz), 130'h1);
        chk("drive in highz", 130'(scan_drive), 130'h0);
        // Clamp drives pins from the held cells while the one-bit bypass path is shifted.
        ir_load(5'h04);
        chk("drive in clamp", 130'(scan_drive), 130'h1);
        chk("bus enable clamp", 130'(data_bus_oe), 130'h0);
        dr_scan(v, got);
        chk("bypass out", got, {1'b0, v[129:1]});
        chk("clamp holds cells", cell_update, v);
        $display("extest test done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        resetn = 1'b0;
        cell_capture = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        go(8'h00, 1);
        t_sample();
        t_extest();
        complete_run();
    end
endmodule
bind bsc_chain bsc_chk #(.CELLS(CELLS)) chk_i (.clk(clk), .resetn(resetn), .tck(tck), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .cell_update(cell_update), .scan_drive(scan_drive), .scan_highz(scan_highz),
    .data_bus_oe(data_bus_oe));

// ===== verif/bsc_chk.sv
// Concurrent checks on the pins of the boundary-scan chain.
`timescale 1ns/1ps
module bsc_chk #(
    parameter int CELLS = 130
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [CELLS-1:0] cell_update,
    input wire logic scan_drive,
    input wire logic scan_highz,
    input wire logic data_bus_oe
);
    logic tck_q;
    logic trst_q;
    logic [3:0] still;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Cycles since the test clock or test reset last moved, saturating at fifteen.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tck_q <= 1'b0;
            trst_q <= 1'b1;
            still <= 4'h0;
        end else begin
            tck_q <= tck;
            trst_q <= trst_n;
            still <= (tck != tck_q || trst_n != trst_q) ? 4'h0 : still + {3'h0, still != 4'hF};
        end
    end
    a_tdo_after_fall: assert property ($changed(tdo) |-> !tck) else $error("tdo moved with tck high");
    a_oe_after_fall: assert property ($changed(tdo_oe) |-> !tck) else $error("tdo_oe moved with tck high");
    a_upd_after_fall: assert property ($changed(cell_update) |-> !tck) else $error("update moved with tck high");
    a_tdo_rise_hold: assert property ($rose(tck) |=> $stable(tdo) [*6]) else $error("tdo moved after rise");
    a_oe_rise_hold: assert property ($rose(tck) |=> $stable(tdo_oe) [*6]) else $error("tdo_oe moved after rise");
    a_dbe_follows_cell: assert property ($stable(scan_drive) && $stable(cell_update[110]) ##1
        $stable(scan_drive) && $stable(cell_update[110]) |-> data_bus_oe == (scan_drive && cell_update[110]))
        else $error("bus enable wrong");
    a_drive_mode_excl: assert property (!(scan_drive && scan_highz)) else $error("drive and float together");
    a_static_hold: assert property (still > 4'h9 |-> $stable(tdo) && $stable(tdo_oe) && $stable(cell_update))
        else $error("state moved while tck stopped");
    cover property ($rose(tdo_oe));
    cover property ($rose(data_bus_oe));
    cover property ($rose(scan_highz));
endmodule

// ===== verif/bsc_ctrl.sv
// Behavioural test controller that clocks the scan port one bit at a time.
`timescale 1ns/1ps
module bsc_ctrl (
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n
);
    // A released serial output is pulled up on the board, so a float reads as one.
    wire line = tdo_oe ? tdo : 1'b1;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (7) @(posedge clk);
        @(negedge clk) o = line;
        @(posedge clk) tck <= 1'b1;
        repeat (8) @(posedge clk);
        tck <= 1'b0;
    endtask
    task automatic tap_reset();
        tms <= 1'b1;
        trst_n <= 1'b0;
        repeat (8) @(posedge clk);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule
